/* pkg/trng_pkg.sv */
package trng_pkg;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    // run of equal raw bits that counts as a failure
    localparam int RUN_LIMIT = 32;
    // cycles without a raw bit before the source counts as dead
    localparam int SRC_TIMEOUT = 1024;
    localparam int WIN_BITS = 256;
    localparam int ONES_LO = 100;
    localparam int ONES_HI = 156;
    // finished words held back before they may leave
    localparam int HOLD_WORDS = 2;
    localparam logic CAUSE_ONLINE = 1'b0;
    localparam logic CAUSE_TOTAL = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_RUN,
        ST_RETEST,
        ST_FAIL
    } gate_state_e;
endpackage : trng_pkg

/* src/word_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module word_fifo
    import trng_pkg::*;
#(
    parameter int W = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("word_fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule : word_fifo
`default_nettype wire

/* src/health_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module health_monitor
    import trng_pkg::*;
#(
    parameter int RUN_MAX = RUN_LIMIT,
    parameter int STALL = SRC_TIMEOUT,
    parameter int WIN = WIN_BITS,
    parameter int LO = ONES_LO,
    parameter int HI = ONES_HI
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic sense,
    input wire logic bit_vld,
    input wire logic bit_in,
    output logic tot_fail,
    output logic win_done,
    output logic win_pass
);
    localparam int RW = $clog2(RUN_MAX + 1);
    localparam int SW = $clog2(STALL + 1);
    localparam int WW = $clog2(WIN + 1);

    if (RUN_MAX < 2 || STALL < 2 || HI < LO || HI > WIN) begin : g_bad_limits
        $error("health_monitor limits out of range");
    end

    logic [RW-1:0] run_q;
    logic last_q;
    logic [SW-1:0] stall_q;
    logic [WW-1:0] win_q;
    logic [WW-1:0] ones_q;

    wire same = (run_q != '0) && (bit_in == last_q);
    // stuck source: too many equal bits, or no bits at all
    wire run_hit = bit_vld && same && (run_q == RW'(RUN_MAX - 1));
    wire stall_hit = sense && !bit_vld && (stall_q == SW'(STALL - 1));
    wire win_last = bit_vld && (win_q == WW'(WIN - 1));
    wire [WW-1:0] ones_next = ones_q + WW'(bit_in);

    assign tot_fail = !restart && (run_hit || stall_hit);
    assign win_done = !restart && win_last;
    assign win_pass = (ones_next >= WW'(LO)) && (ones_next <= WW'(HI));

    always_ff @(posedge clk) begin
        if (rst || restart) begin
            run_q <= '0;
            last_q <= 1'b0;
            stall_q <= '0;
            win_q <= '0;
            ones_q <= '0;
        end else begin
            if (bit_vld) begin
                last_q <= bit_in;
                run_q <= same ? (run_hit ? run_q : run_q + 1'b1) : RW'(1);
                win_q <= win_last ? '0 : win_q + 1'b1;
                ones_q <= win_last ? '0 : ones_next;
            end
            stall_q <= (bit_vld || !sense || stall_hit) ? '0 : stall_q + 1'b1;
        end
    end
endmodule : health_monitor
`default_nettype wire

/* src/true_random_health_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module true_random_health_gate
    import trng_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int HOLD = HOLD_WORDS,
    parameter int RUN_MAX = RUN_LIMIT,
    parameter int STALL = SRC_TIMEOUT,
    parameter int WIN = WIN_BITS,
    parameter int LO = ONES_LO,
    parameter int HI = ONES_HI
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic raw_valid,
    input wire logic raw_bit,
    output logic raw_ready,
    input wire logic retest_req,
    input wire logic fail_clr,
    output logic [trng_pkg::WORD_W-1:0] rnd_word,
    output logic rnd_valid,
    input wire logic rnd_ready,
    output logic online_ok,
    output logic testing,
    output logic fail_flag,
    output logic fail_cause
);
    import trng_pkg::*;

    localparam int BW = $clog2(WORD_W);

    // held-back words must cover every bit a stuck run can reach
    if (HOLD < 2 || RUN_MAX > HOLD * WORD_W) begin : g_bad_hold
        $error("hold-back depth too short for the run limit");
    end

    gate_state_e state_q;
    gate_state_e state_d;
    logic restart_q;
    logic fail_q;
    logic cause_q;
    logic [WORD_W-1:0] sh_q;
    logic [BW-1:0] bcnt_q;
    logic [WORD_W-1:0] pend_q [HOLD];
    logic [HOLD-1:0] pend_v_q;

    logic tot_fail;
    logic win_done;
    logic win_pass;
    logic fifo_in_rdy;
    logic fifo_out_vld;

    wire in_run = (state_q == ST_RUN);
    wire in_test = (state_q == ST_START) || (state_q == ST_RETEST);
    wire online_fail = win_done && !win_pass;
    wire fail_evt = tot_fail || online_fail;
    wire run_ok = in_run && !fail_evt;
    wire word_end = (bcnt_q == BW'(WORD_W - 1));
    wire fifo_stall = in_run && word_end && pend_v_q[HOLD-1] && !fifo_in_rdy;
    wire take = raw_valid && raw_ready;
    wire word_done = take && run_ok && word_end;
    wire [WORD_W-1:0] word_new = {sh_q[WORD_W-2:0], raw_bit};
    wire fifo_in_vld = word_done && pend_v_q[HOLD-1];
    wire health_restart = (state_q == ST_IDLE) || (state_q == ST_FAIL) || restart_q;
    wire flush = fail_evt || (state_q == ST_IDLE);

    // back-pressure from a full queue stops the raw stream
    assign raw_ready = !fifo_stall;
    assign rnd_valid = fifo_out_vld && run_ok;
    assign online_ok = in_run;
    assign testing = in_test;
    assign fail_flag = fail_q;
    assign fail_cause = cause_q;

    health_monitor #(
        .RUN_MAX(RUN_MAX),
        .STALL(STALL),
        .WIN(WIN),
        .LO(LO),
        .HI(HI)
    ) u_health (
        .clk(clk),
        .rst(rst),
        .restart(health_restart),
        .sense(raw_ready),
        .bit_vld(take),
        .bit_in(raw_bit),
        .tot_fail(tot_fail),
        .win_done(win_done),
        .win_pass(win_pass)
    );

    word_fifo #(
        .W(WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(flush),
        .in_valid(fifo_in_vld),
        .in_ready(fifo_in_rdy),
        .in_data(pend_q[HOLD-1]),
        .out_valid(fifo_out_vld),
        .out_ready(rnd_ready && rnd_valid),
        .out_data(rnd_word)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                // a recorded failure needs fail_clr before a restart
                if (enable && !fail_q) begin
                    state_d = ST_START;
                end
            end
            ST_START, ST_RETEST: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                end else if (fail_evt) begin
                    state_d = ST_FAIL;
                end else if (win_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                end else if (fail_evt) begin
                    state_d = ST_FAIL;
                end else if (retest_req) begin
                    state_d = ST_RETEST;
                end
            end
            ST_FAIL: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                end else if (fail_clr) begin
                    state_d = ST_START;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            restart_q <= 1'b0;
        end else begin
            state_q <= state_d;
            restart_q <= (state_d == ST_RETEST) && (state_q != ST_RETEST);
        end
    end

    // sticky flag: a new failure beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            fail_q <= 1'b0;
            cause_q <= CAUSE_ONLINE;
        end else begin
            fail_q <= fail_evt || (fail_q && !fail_clr);
            if (fail_evt) begin
                cause_q <= tot_fail ? CAUSE_TOTAL : CAUSE_ONLINE;
            end
        end
    end

    // bit packing and hold-back of finished words
    always_ff @(posedge clk) begin
        if (rst || !run_ok) begin
            bcnt_q <= '0;
            pend_v_q <= '0;
        end else if (take) begin
            sh_q <= word_new;
            bcnt_q <= bcnt_q + 1'b1;
            if (word_end) begin
                pend_q[0] <= word_new;
                pend_v_q <= {pend_v_q[HOLD-2:0], 1'b1};
                for (int i = 1; i < HOLD; i++) begin
                    pend_q[i] <= pend_q[i-1];
                end
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_blocked4;
        !rnd_valid [*4];
    endsequence

    sequence s_failed_hold;
        (state_q == ST_FAIL) && fail_q;
    endsequence

    property p_total_blocks;
        tot_fail && !fail_clr |-> s_blocked4;
    endproperty
    a_total_blocks: assert property (p_total_blocks)
        else $error("word offered after total failure");

    property p_discard_after_fail;
        fail_evt |=> !fifo_out_vld && (pend_v_q == '0) && (bcnt_q == '0);
    endproperty
    a_discard_after_fail: assert property (p_discard_after_fail)
        else $error("post-failure bits survived");

    property p_online_to_fail;
        in_run && enable && online_fail |=> s_failed_hold;
    endproperty
    a_online_to_fail: assert property (p_online_to_fail)
        else $error("online defect did not stop the generator");

    property p_only_when_passed;
        rnd_valid |-> in_run && !fail_q && !fail_evt && $past(state_q) != ST_IDLE;
    endproperty
    a_only_when_passed: assert property (p_only_when_passed)
        else $error("output while not cleared by the online test");

    property p_word_held;
        rnd_valid && !rnd_ready && !fail_evt && enable && !retest_req
            |=> fail_evt || (rnd_valid && $stable(rnd_word));
    endproperty
    a_word_held: assert property (p_word_held)
        else $error("offered word changed before it was taken");

    property p_retest;
        in_run && enable && retest_req && !fail_evt
            |=> (state_q == ST_RETEST) && !rnd_valid ##1 !rnd_valid;
    endproperty
    a_retest: assert property (p_retest)
        else $error("internal event did not restart the online test");

    property p_sticky;
        fail_q && !fail_clr |=> fail_q;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("failure flag dropped without a clear");

    sequence s_window_pass;
        in_test && enable && win_done && win_pass && !tot_fail;
    endsequence

    sequence s_clear_taken;
        (state_q == ST_FAIL) && enable && fail_clr;
    endsequence

    property p_pass_to_run;
        s_window_pass |=> in_run;
    endproperty
    a_pass_to_run: assert property (p_pass_to_run)
        else $error("passed online test did not release the generator");

    property p_test_blocks;
        in_test |-> !rnd_valid && !online_ok;
    endproperty
    a_test_blocks: assert property (p_test_blocks)
        else $error("word offered while the online test runs");

    property p_fail_blocks;
        (state_q == ST_FAIL) |-> !rnd_valid && !fifo_out_vld && fail_q;
    endproperty
    a_fail_blocks: assert property (p_fail_blocks)
        else $error("words kept or offered in the failed state");

    property p_cause_total;
        tot_fail |=> fail_flag && (fail_cause == CAUSE_TOTAL);
    endproperty
    a_cause_total: assert property (p_cause_total)
        else $error("total failure not recorded");

    property p_cause_online;
        online_fail && !tot_fail |=> fail_flag && (fail_cause == CAUSE_ONLINE);
    endproperty
    a_cause_online: assert property (p_cause_online)
        else $error("online defect not recorded");

    property p_idle_flush;
        (state_q == ST_IDLE) |=> !fifo_out_vld && (pend_v_q == '0);
    endproperty
    a_idle_flush: assert property (p_idle_flush)
        else $error("words survived while the generator was off");

    property p_start_entry;
        (state_q == ST_IDLE) && enable && !fail_q |=> in_test && !rnd_valid;
    endproperty
    a_start_entry: assert property (p_start_entry)
        else $error("start-up test not entered on enable");

    property p_disable;
        !enable && (state_q != ST_IDLE) |=> (state_q == ST_IDLE) && !rnd_valid;
    endproperty
    a_disable: assert property (p_disable)
        else $error("generator kept running after disable");

    property p_clear_restart;
        s_clear_taken |=> in_test && !fail_flag;
    endproperty
    a_clear_restart: assert property (p_clear_restart)
        else $error("failure clear did not restart the start-up test");

    property p_word_queued;
        word_done && pend_v_q[HOLD-1] |=> fifo_out_vld;
    endproperty
    a_word_queued: assert property (p_word_queued)
        else $error("finished word did not reach the queue");
endmodule : true_random_health_gate
`default_nettype wire

/* verif/rng_reader.sv */
`timescale 1ns/100ps
`default_nettype none
module rng_reader
    import trng_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic accept,
    input wire logic rnd_valid,
    input wire logic [trng_pkg::WORD_W-1:0] rnd_word,
    output logic rnd_ready
);
    logic [WORD_W-1:0] got [$];
    initial rnd_ready = 1'b0;
    // words only recorded; whitening is the reader's job
    always @(posedge clk) begin
        if (rst) begin
            got.delete();
        end else if (rnd_valid && rnd_ready) begin
            got.push_back(rnd_word);
        end
        rnd_ready <= accept && !rst;
    end
endmodule : rng_reader
`default_nettype wire

/* verif/test_true_random_health_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module test_true_random_health_gate;
    import trng_pkg::*;
    logic clk, rst, enable, raw_valid, raw_bit, raw_ready, retest_req, fail_clr;
    logic [WORD_W-1:0] rnd_word;
    logic rnd_valid, rnd_ready, online_ok, testing, fail_flag, fail_cause, accept;
    int err_total = 0;
    int checks_done = 0;
    logic [15:0] wt [11] = '{16'hA5A5, 16'h5A5A, 16'h3C3C, 16'hC3C3, 16'h6969, 16'h9696,
        16'h33CC, 16'hCC33, 16'hA55A, 16'h5AA5, 16'h3CC3};

    true_random_health_gate #(.RUN_MAX(8), .STALL(16), .WIN(16), .LO(4), .HI(12)) i_dut (
        .clk(clk), .rst(rst), .enable(enable),
        .raw_valid(raw_valid), .raw_bit(raw_bit), .raw_ready(raw_ready),
        .retest_req(retest_req), .fail_clr(fail_clr), .rnd_word(rnd_word),
        .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .online_ok(online_ok),
        .testing(testing), .fail_flag(fail_flag), .fail_cause(fail_cause));
    rng_reader i_reader (.clk(clk), .rst(rst), .accept(accept), .rnd_valid(rnd_valid),
        .rnd_word(rnd_word), .rnd_ready(rnd_ready));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task stop_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        enable <= 1'b0;
        accept <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    // one raw bit per cycle, first bit from the top
    task send(input logic [15:0] w, input int n);
        int k;
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            raw_valid <= 1'b1;
            raw_bit <= w[15-i];
            k = 0;
            @(negedge clk);
            while (raw_ready !== 1'b1 && k < 200) begin
                @(negedge clk);
                k++;
            end
            @(posedge clk);
        end
        raw_valid <= 1'b0;
    endtask : send

    task wait_neg(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_neg

    task wait_fail;
        int k;
        k = 0;
        while (fail_flag !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        check(fail_flag, 1'b1);
        check(online_ok, 1'b0);
        check(rnd_valid, 1'b0);
    endtask : wait_fail

    task start_run;
        @(posedge clk);
        enable <= 1'b1;
        wait_neg(2);
        check(testing, 1'b1);
        check(rnd_valid, 1'b0);
        send(16'hA5A5, 16);
        wait_neg(2);
        check(online_ok, 1'b1);
        check(fail_flag, 1'b0);
    endtask : start_run

    task t_idle;
        do_reset();
        wait_neg(1);
        check({online_ok, testing, fail_flag, rnd_valid, raw_ready}, 5'h01);
    endtask : t_idle

    task t_flow;
        do_reset();
        start_run();
        send(wt[0], 16);
        send(wt[1], 16);
        wait_neg(3);
        check(16'(i_reader.got.size()), 16'h0000);
        send(wt[2], 16);
        wait_neg(4);
        check(16'(i_reader.got.size()), 16'h0001);
        check(i_reader.got[0], wt[0]);
    endtask : t_flow

    task t_fill;
        do_reset();
        accept <= 1'b0;
        start_run();
        for (int i = 0; i < 10; i++) send(wt[i], 16);
        send(wt[10], 15);
        @(posedge clk);
        raw_valid <= 1'b1;
        raw_bit <= wt[10][0];
        wait_neg(2);
        check(raw_ready, 1'b0);
        @(posedge clk);
        accept <= 1'b1;
        send({wt[10][0], 15'h0000}, 1);
        wait_neg(12);
        check(16'(i_reader.got.size()), 16'h0009);
        for (int i = 0; i < 9; i++) check(i_reader.got[i], wt[i]);
        check(rnd_valid, 1'b0);
    endtask : t_fill

    task t_stuck;
        do_reset();
        start_run();
        send(wt[0], 16);
        send(wt[1], 16);
        send(16'hFF00, 8);
        wait_fail();
        check(fail_cause, CAUSE_TOTAL);
        check(16'(i_reader.got.size()), 16'h0000);
        @(posedge clk);
        fail_clr <= 1'b1;
        @(posedge clk);
        fail_clr <= 1'b0;
        send(16'hA5A5, 16);
        wait_neg(2);
        check({online_ok, fail_flag}, 2'h2);
    endtask : t_stuck

    task t_stall;
        do_reset();
        @(posedge clk);
        enable <= 1'b1;
        wait_neg(2);
        wait_fail();
        check(fail_cause, CAUSE_TOTAL);
    endtask : t_stall

    task t_bad_window;
        do_reset();
        @(posedge clk);
        enable <= 1'b1;
        send(16'h0204, 16);
        wait_fail();
        check(fail_cause, CAUSE_ONLINE);
    endtask : t_bad_window

    task t_retest;
        do_reset();
        accept <= 1'b0;
        start_run();
        for (int i = 0; i < 3; i++) send(wt[i], 16);
        wait_neg(3);
        check({rnd_valid, rnd_word}, {1'b1, wt[0]});
        @(posedge clk);
        retest_req <= 1'b1;
        @(posedge clk);
        retest_req <= 1'b0;
        wait_neg(2);
        check({testing, online_ok, rnd_valid}, 3'h4);
        send(16'h5A5A, 16);
        wait_neg(2);
        check({online_ok, rnd_valid, rnd_word}, {2'h3, wt[0]});
    endtask : t_retest

    task t_disable;
        do_reset();
        accept <= 1'b0;
        start_run();
        for (int i = 0; i < 3; i++) send(wt[i], 16);
        @(posedge clk);
        enable <= 1'b0;
        wait_neg(2);
        check({online_ok, testing, rnd_valid}, 3'h0);
        start_run();
        wait_neg(2);
        check(rnd_valid, 1'b0);
    endtask : t_disable

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        enable = 1'b0;
        raw_valid = 1'b0;
        raw_bit = 1'b0;
        retest_req = 1'b0;
        fail_clr = 1'b0;
        accept = 1'b0;
        t_idle();
        t_flow();
        t_fill();
        t_stuck();
        t_stall();
        t_bad_window();
        t_retest();
        t_disable();
        stop_test();
    end
endmodule : test_true_random_health_gate
`default_nettype wire
